/* lipd_defs.svh */
// Purpose: Shared constants of the lip-sync delay line
// Assumes: Included by its bare name from the design files
// Notes:   Widths and counts are fixed, not parameters
`ifndef LIPD_DEFS_SVH
`define LIPD_DEFS_SVH

`define LIPD_WORD_W   24
`define LIPD_FRAME_W  48
`define LIPD_ADDR_W   13
`define LIPD_DEPTH    8192
`define LIPD_SEL_W    5
`define LIPD_SYNC_W   8
`define LIPD_CNT_W    5
`define LIPD_DLY_LOW  8'hFF
`define LIPD_CLR_LAST 13'h1FFF
`define LIPD_ADDR_ONE 13'h0001
`define LIPD_CNT_MAX  5'h18
`define LIPD_RST_CODE 5'h00

`endif

/* lipd_pkg.sv */
// Purpose: Types of the lip-sync delay line
// Assumes: Nothing
// Notes:   One-hot control states
package lipd_pkg;
	typedef enum logic [1:0] {
		LIPD_CLEAR = 2'h1,
		LIPD_RUN   = 2'h2
	} lipd_state_t;
endpackage

/* lipd_sync.sv */
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs asynchronous to mclk
// Notes:   Output follows once stages two and three agree
`timescale 1ns/100ps
`include "lipd_defs.svh"
module lipd_sync (
	input  wire logic                     mclk,
	input  wire logic                     reset_n,
	input  wire logic [`LIPD_SYNC_W-1:0]  pin_in,
	output logic      [`LIPD_SYNC_W-1:0]  pin_out
);
	logic [`LIPD_SYNC_W-1:0] s1_r;
	logic [`LIPD_SYNC_W-1:0] s2_r;
	logic [`LIPD_SYNC_W-1:0] s3_r;

	genvar i;
	generate
		for (i = 0; i < `LIPD_SYNC_W; i = i + 1) begin : g_bit
			always_ff @(posedge mclk or negedge reset_n) begin
				if (!reset_n) begin
					s1_r[i]    <= 1'b0;
					s2_r[i]    <= 1'b0;
					s3_r[i]    <= 1'b0;
					pin_out[i] <= 1'b0;
				end else begin
					s1_r[i] <= pin_in[i];
					s2_r[i] <= s1_r[i];
					s3_r[i] <= s2_r[i];
					// A lone glitch in stage two never reaches the output
					if (s2_r[i] == s3_r[i]) begin
						pin_out[i] <= s3_r[i];
					end
				end
			end
		end
	endgenerate
endmodule

/* lipd_mem.sv */
// Purpose: Stereo sample store, one frame per word
// Assumes: One write and one read port on mclk
// Notes:   Read data is registered, one cycle after the request
`timescale 1ns/100ps
`include "lipd_defs.svh"
module lipd_mem (
	input  wire logic                     mclk,
	input  wire logic                     wr_en,
	input  wire logic [`LIPD_ADDR_W-1:0]  wr_addr,
	input  wire logic [`LIPD_FRAME_W-1:0] wr_data,
	input  wire logic                     rd_en,
	input  wire logic [`LIPD_ADDR_W-1:0]  rd_addr,
	output logic      [`LIPD_FRAME_W-1:0] rd_data
);
	logic [`LIPD_FRAME_W-1:0] mem [0:`LIPD_DEPTH-1];

	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

/* lipd_top.sv */
// Purpose: Stereo serial audio delay line clocked by mclk, with the link clocks sampled as inputs
// Assumes: Bit clock far slower than mclk, sampled as a plain input
// Notes:   Output frame lags the input by the selected sample count
`timescale 1ns/100ps
`include "lipd_defs.svh"
module lipd_top (
	input  wire logic mclk,
	input  wire logic reset_n,
	input  wire logic audio_bit_clk,
	input  wire logic audio_word_clk,
	input  wire logic audio_data_in,
	input  wire logic delay_sel_bit0,
	input  wire logic delay_sel_bit1,
	input  wire logic delay_sel_bit2,
	input  wire logic delay_sel_bit3,
	input  wire logic delay_sel_bit4,
	output logic      audio_data_out
);
	logic [`LIPD_SYNC_W-1:0]  pins_f;
	logic [`LIPD_SEL_W-1:0]   delay_select_code;
	logic                     bclk_f;
	logic                     lr_f;
	logic                     din_f;
	logic                     bclk_d_r;
	logic                     rise;
	logic                     fall;
	logic                     lr_prev_r;
	logic                     lr_chg;
	logic [`LIPD_WORD_W-1:0]  acc_r;
	logic [`LIPD_CNT_W-1:0]   cnt_r;
	logic [`LIPD_WORD_W-1:0]  word_now;
	logic [`LIPD_WORD_W-1:0]  left_r;
	logic                     frame_done;
	lipd_pkg::lipd_state_t    state_r;
	logic [`LIPD_SEL_W-1:0]   code_r;
	logic                     code_chg;
	logic [`LIPD_ADDR_W-1:0]  clr_addr_r;
	logic [`LIPD_ADDR_W-1:0]  wp_r;
	logic [`LIPD_ADDR_W-1:0]  fill_r;
	logic [`LIPD_ADDR_W-1:0]  dly;
	logic                     muted;
	logic                     wr_en;
	logic [`LIPD_ADDR_W-1:0]  wr_addr;
	logic [`LIPD_FRAME_W-1:0] wr_data;
	logic                     rd_en;
	logic [`LIPD_ADDR_W-1:0]  rd_addr;
	logic [`LIPD_FRAME_W-1:0] rd_data;
	logic                     rd_valid_r;
	logic [`LIPD_WORD_W-1:0]  out_l_r;
	logic [`LIPD_WORD_W-1:0]  out_rt_r;
	logic                     mute_hold_r;
	logic                     tx_load_r;
	logic                     tx_chan_r;
	logic [`LIPD_WORD_W-1:0]  tx_sh_r;

	function automatic logic [`LIPD_ADDR_W-1:0] lipd_delay(
		input logic [`LIPD_SEL_W-1:0] code
	);
		lipd_delay = {code, `LIPD_DLY_LOW};
	endfunction

	function automatic logic [`LIPD_WORD_W-1:0] lipd_put(
		input logic [`LIPD_WORD_W-1:0] acc,
		input logic [`LIPD_CNT_W-1:0]  cnt,
		input logic                    bit_in
	);
		logic [`LIPD_WORD_W-1:0] res;
		res = acc;
		// Bits past the 24th are dropped; shorter words pad with zero
		if (cnt < `LIPD_CNT_MAX) begin
			res[`LIPD_WORD_W-1-cnt] = bit_in;
		end
		lipd_put = res;
	endfunction

	// Every link and delay select pin, clocks included, is sampled by mclk
	lipd_sync u_sync (
		.mclk    (mclk),
		.reset_n (reset_n),
		.pin_in  ({delay_sel_bit4, delay_sel_bit3, delay_sel_bit2,
		           delay_sel_bit1, delay_sel_bit0, audio_data_in,
		           audio_word_clk, audio_bit_clk}),
		.pin_out (pins_f)
	);

	assign bclk_f            = pins_f[0];
	assign lr_f              = pins_f[1];
	assign din_f             = pins_f[2];
	assign delay_select_code = pins_f[7:3];

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bclk_d_r <= 1'b0;
		end else begin
			bclk_d_r <= bclk_f;
		end
	end

	assign rise       = bclk_f & ~bclk_d_r;
	assign fall       = ~bclk_f & bclk_d_r;
	assign lr_chg     = rise & (lr_f != lr_prev_r);
	assign word_now   = lipd_put(acc_r, cnt_r, din_f);
	// Word clock low again means the right word just finished
	assign frame_done = lr_chg & ~lr_f;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lr_prev_r <= 1'b0;
			acc_r     <= '0;
			cnt_r     <= '0;
		end else if (rise) begin
			lr_prev_r <= lr_f;
			if (lr_chg) begin
				acc_r <= '0;
				cnt_r <= '0;
			end else begin
				acc_r <= word_now;
				if (cnt_r != `LIPD_CNT_MAX) begin
					cnt_r <= cnt_r + 5'h01;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			left_r <= '0;
		end else if (lr_chg && lr_f) begin
			left_r <= word_now;
		end
	end

	assign code_chg = (delay_select_code != code_r);
	assign dly      = lipd_delay(code_r);

	// The sweep costs 8192 mclk cycles; frames arriving meanwhile are lost
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_r    <= lipd_pkg::LIPD_CLEAR;
			code_r     <= `LIPD_RST_CODE;
			clr_addr_r <= '0;
		end else if (code_chg) begin
			state_r    <= lipd_pkg::LIPD_CLEAR;
			code_r     <= delay_select_code;
			clr_addr_r <= '0;
		end else begin
			case (state_r)
				lipd_pkg::LIPD_CLEAR: begin
					clr_addr_r <= clr_addr_r + `LIPD_ADDR_ONE;
					if (clr_addr_r == `LIPD_CLR_LAST) begin
						state_r <= lipd_pkg::LIPD_RUN;
					end
				end
				lipd_pkg::LIPD_RUN: begin
					state_r <= lipd_pkg::LIPD_RUN;
				end
				default: begin
					state_r <= lipd_pkg::LIPD_CLEAR;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wp_r   <= '0;
			fill_r <= '0;
		end else if (state_r != lipd_pkg::LIPD_RUN) begin
			wp_r   <= '0;
			fill_r <= '0;
		end else if (frame_done) begin
			wp_r <= wp_r + `LIPD_ADDR_ONE;
			if (fill_r < dly) begin
				fill_r <= fill_r + `LIPD_ADDR_ONE;
			end
		end
	end

	assign muted   = (fill_r < dly);
	assign wr_en   = (state_r == lipd_pkg::LIPD_CLEAR) ||
	                 ((state_r == lipd_pkg::LIPD_RUN) && frame_done);
	assign wr_addr = (state_r == lipd_pkg::LIPD_CLEAR) ? clr_addr_r : wp_r;
	assign wr_data = (state_r == lipd_pkg::LIPD_CLEAR) ?
	                 '0 : {left_r, word_now};
	assign rd_en   = (state_r == lipd_pkg::LIPD_RUN) && frame_done;
	// Plus one because the read frame goes out during the next frame
	assign rd_addr = wp_r + `LIPD_ADDR_ONE - dly;

	lipd_mem u_mem (
		.mclk    (mclk),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.rd_en   (rd_en),
		.rd_addr (rd_addr),
		.rd_data (rd_data)
	);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rd_valid_r  <= 1'b0;
			out_l_r     <= '0;
			out_rt_r    <= '0;
			mute_hold_r <= 1'b1;
		end else begin
			rd_valid_r <= rd_en;
			if (state_r != lipd_pkg::LIPD_RUN) begin
				mute_hold_r <= 1'b1;
			end else if (rd_valid_r) begin
				out_l_r     <= rd_data[`LIPD_FRAME_W-1:`LIPD_WORD_W];
				out_rt_r    <= rd_data[`LIPD_WORD_W-1:0];
				mute_hold_r <= muted;
			end
		end
	end

	// Load after the word clock edge, then one bit per falling edge
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_load_r      <= 1'b0;
			tx_chan_r      <= 1'b0;
			tx_sh_r        <= '0;
			audio_data_out <= 1'b0;
		end else if (lr_chg) begin
			tx_load_r <= 1'b1;
			tx_chan_r <= lr_f;
		end else if (fall) begin
			tx_load_r <= 1'b0;
			if (tx_load_r) begin
				if (mute_hold_r) begin
					tx_sh_r        <= '0;
					audio_data_out <= 1'b0;
				end else if (tx_chan_r) begin
					tx_sh_r        <= {out_rt_r[`LIPD_WORD_W-2:0], 1'b0};
					audio_data_out <= out_rt_r[`LIPD_WORD_W-1];
				end else begin
					tx_sh_r        <= {out_l_r[`LIPD_WORD_W-2:0], 1'b0};
					audio_data_out <= out_l_r[`LIPD_WORD_W-1];
				end
			end else begin
				tx_sh_r        <= {tx_sh_r[`LIPD_WORD_W-2:0], 1'b0};
				audio_data_out <= tx_sh_r[`LIPD_WORD_W-1];
			end
		end
	end

	property p_clear_on_change;
		@(posedge mclk) disable iff (!reset_n)
		code_chg |=> (state_r == lipd_pkg::LIPD_CLEAR) && (clr_addr_r == '0);
	endproperty
	a_clear_on_change: assert property (p_clear_on_change)
		else $error("Code change did not restart the clear sweep");

	property p_clear_zero;
		@(posedge mclk) disable iff (!reset_n)
		(state_r == lipd_pkg::LIPD_CLEAR) |-> wr_en && (wr_data == '0);
	endproperty
	a_clear_zero: assert property (p_clear_zero)
		else $error("Clear sweep wrote nonzero data");

	property p_out_on_fall;
		@(posedge mclk) disable iff (!reset_n)
		$changed(audio_data_out) |-> $past(fall);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall)
		else $error("Output bit changed away from a falling edge");

	property p_shift_on_rise;
		@(posedge mclk) disable iff (!reset_n)
		(cnt_r != $past(cnt_r)) && (cnt_r != '0) |-> $past(rise);
	endproperty
	a_shift_on_rise: assert property (p_shift_on_rise)
		else $error("Input bit taken without a rising edge");

	property p_wp_step;
		@(posedge mclk) disable iff (!reset_n || code_chg)
		rd_en |=> (wp_r == $past(wp_r) + `LIPD_ADDR_ONE) && rd_valid_r;
	endproperty
	a_wp_step: assert property (p_wp_step)
		else $error("Write pointer did not advance one frame");

	property p_rd_offset;
		@(posedge mclk) disable iff (!reset_n)
		// Offset rebuilt from the code itself, not from the delay function
		rd_en |-> ((wp_r - rd_addr) == {code_r, 8'hFE});
	endproperty
	a_rd_offset: assert property (p_rd_offset)
		else $error("Read offset does not match the selected delay");

	property p_mute_zero;
		@(posedge mclk) disable iff (!reset_n)
		fall && tx_load_r && mute_hold_r && !lr_chg |=> !audio_data_out;
	endproperty
	a_mute_zero: assert property (p_mute_zero)
		else $error("Muted frame drove a one");

	property p_fill_bound;
		@(posedge mclk) disable iff (!reset_n)
		(fill_r <= dly) || $past(code_chg);
	endproperty
	a_fill_bound: assert property (p_fill_bound)
		else $error("Fill count ran past the delay");

	property p_frame_write;
		@(posedge mclk) disable iff (!reset_n)
		wr_en && (state_r == lipd_pkg::LIPD_RUN) |-> frame_done && !lr_f;
	endproperty
	a_frame_write: assert property (p_frame_write)
		else $error("Frame stored away from the left word edge");

	c_clear_done: cover property (@(posedge mclk) disable iff (!reset_n)
		state_r == lipd_pkg::LIPD_CLEAR ##1 state_r == lipd_pkg::LIPD_RUN);
	c_unmute: cover property (@(posedge mclk) disable iff (!reset_n)
		mute_hold_r ##1 !mute_hold_r);
	c_frame: cover property (@(posedge mclk) disable iff (!reset_n)
		rd_en ##1 rd_valid_r);
endmodule

/* lipd_link_model.sv */
// Purpose: Serial audio source and sink facing the delay line
// Assumes: Continuous back-to-back frames, bit clock period 800 ns
// Notes:   Sink samples just before each fall, as the output moves late
`timescale 1ns/100ps
module lipd_link_model (
	output logic      bit_clk,
	output logic      word_clk,
	output logic      data_out,
	input  wire logic data_back
);
	logic [63:0] cap_r;
	logic        prev_bit;

	initial begin
		bit_clk = 1'b0;
		word_clk = 1'b0;
		data_out = 1'b1;
		prev_bit = 1'b0;
		cap_r = 64'h0;
	end

	// Slot 0 carries the last bit of the previous stream: one-bit delay
	task automatic frame(input int h, input logic [63:0] strm,
		output logic [63:0] got);
		for (int i = 0; i < 2 * h; i++) begin
			word_clk = (i >= h);
			data_out = (i == 0) ? prev_bit : strm[2 * h - i];
			#400 bit_clk = 1'b1;
			#400 cap_r = {cap_r[62:0], data_back};
			if (i == 0) begin
				got = cap_r;
			end
			bit_clk = 1'b0;
		end
		prev_bit = strm[0];
	endtask
endmodule

/* lipd_top_test.sv */
// Purpose: Self-checking bench of the lip-sync delay line
// Assumes: Delay code zero, 20 bit slots per half frame
// Notes:   Longer codes cost over 100k cycles, so only code zero runs
`timescale 1ns/100ps
module lipd_top_test;
	localparam int H   = 20;
	localparam int DLY = 255;
	localparam int NFR = DLY + 7;

	logic        mclk;
	logic        reset_n;
	logic        bclk;
	logic        wclk;
	logic        din;
	logic        dout;
	logic [4:0]  sel;
	logic [63:0] sent [NFR];
	logic [63:0] got;
	logic [23:0] lv;
	logic [23:0] rv;
	int          bad_count;
	int          check_count;
	int          seed;
	int          wl;

	lipd_top uut (
		.mclk           (mclk),
		.reset_n        (reset_n),
		.audio_bit_clk  (bclk),
		.audio_word_clk (wclk),
		.audio_data_in  (din),
		.delay_sel_bit0 (sel[0]),
		.delay_sel_bit1 (sel[1]),
		.delay_sel_bit2 (sel[2]),
		.delay_sel_bit3 (sel[3]),
		.delay_sel_bit4 (sel[4]),
		.audio_data_out (dout)
	);

	lipd_link_model link (
		.bit_clk   (bclk),
		.word_clk  (wclk),
		.data_out  (din),
		.data_back (dout)
	);

	always #50 mclk = ~mclk;

	task automatic check(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Word of wl bits, left-justified, cut to the H slots of one half
	function automatic logic [63:0] half(input int n, input logic [23:0] v);
		logic [31:0] s;
		s = {v, 8'h00} & ~(32'hFFFFFFFF >> n);
		return {32'h0, s >> (32 - H)};
	endfunction

	initial begin
		#9800000;
		bad_count++;
		finish_test();
	end

	initial begin
		mclk = 1'b0;
		reset_n = 1'b0;
		sel = 5'h00;
		seed = 91;
		bad_count = 0;
		check_count = 0;
		repeat (10) @(negedge mclk);
		reset_n = 1'b1;
		// Frames sent during the sweep would be lost, so wait it out
		for (int c = 0; c < 8900; c++) begin
			@(negedge mclk);
			// Each code change restarts the sweep; the last ends near 8800
			if (c == 500) begin
				sel = 5'h01;
			end
			if (c == 600) begin
				sel = 5'h00;
			end
			if (c % 128 == 0) begin
				check("quiet_in_clear", {63'h0, dout}, 64'h0);
			end
		end
		for (int j = 0; j < NFR; j++) begin
			wl = 16 + int'({$random(seed)} % 5);
			lv = 24'($random(seed));
			rv = 24'($random(seed));
			if (j % 64 == 3) begin
				wl = 20;
				lv = 24'hFFFFFF;
				rv = 24'h800001;
			end
			if (j % 64 == 5) begin
				wl = 16;
				lv = 24'h000100;
				rv = 24'hFFFF00;
			end
			sent[j] = (half(wl, lv) << H) | half(wl, rv);
			link.frame(H, sent[j], got);
			if (j >= 1 && j - 1 <= DLY - 1) begin
				check("muted_frame", got & ((64'h1 << 2 * H) - 1),
					64'h0);
			end
			// Frame 0 has no word clock edge before it, so its left is unframed
			if (j - 1 > DLY) begin
				check("left_word", (got >> H) & ((64'h1 << H) - 1),
					sent[j - 1 - DLY] >> H);
				check("right_word", got & ((64'h1 << H) - 1),
					sent[j - 1 - DLY] & ((64'h1 << H) - 1));
			end
		end
		finish_test();
	end
endmodule
